// ===== logic/psif_params.svh
// register map, field positions, codes and reset values of the status block
`ifndef PSIF_PARAMS_SVH
`define PSIF_PARAMS_SVH

`define PSIF_ADDR_W 18
`define PSIF_BYTE_ADDR(i) ({(i), 2'b00})

`define PSIF_IDX_CTRL 16'h2004
`define PSIF_IDX_STATUS 16'h2020
`define PSIF_IDX_STAT_RSV1 16'h2021
`define PSIF_IDX_STAT_RSV3 16'h2023
`define PSIF_IDX_STOP 16'h2024
`define PSIF_IDX_STOP_RSV1 16'h2025
`define PSIF_IDX_STOP_RSV2 16'h2026
`define PSIF_IDX_STOP_RSV3 16'h2027
`define PSIF_IDX_MASK 16'h2030
`define PSIF_IDX_FORM 16'h2050

`define PSIF_DONE_BIT 0
`define PSIF_INTERRUPT_ENABLE_BIT_BIT 8
`define PSIF_STOP_MSB 3
`define PSIF_FORM_MSB 3
`define PSIF_BYTE_MSB 7
`define PSIF_LANE0 0
`define PSIF_LANE1 1

`define PSIF_FORM_RESET 8'h2a
`define PSIF_FLAG_RESET 1'b0
`define PSIF_WORD_ZERO 32'h0000_0000

`define PSIF_STOP_NORMAL 4'h0
`define PSIF_STOP_HALT 4'h1
`define PSIF_STOP_NO_INVERSE 4'h2
`define PSIF_STOP_OFF_CURVE 4'h3
`define PSIF_STOP_BAD_UCODE 4'h4

`endif

// ===== logic/psif_pkg.sv
// types shared by the status block and its conversion sequencer
`include "psif_params.svh"
package psif_pkg;
  typedef enum logic [2:0] {
    PSIF_IDLE = 3'b000,
    PSIF_CONV_J0 = 3'b001,
    PSIF_CONV_M0 = 3'b010,
    PSIF_CONV_J1 = 3'b011,
    PSIF_CONV_M1 = 3'b100,
    PSIF_RUN = 3'b101
  } psif_prep_e;
  // member order matches form register bits 3..0
  typedef struct packed {
    logic mon1;
    logic aff1;
    logic mon0;
    logic aff0;
  } psif_form_s;
  typedef struct packed {
    logic halt;
    logic no_inverse;
    logic off_curve;
    logic bad_ucode;
  } psif_fault_s;
  typedef struct packed {
    logic req;
    logic operand;
    logic to_mont;
  } psif_conv_s;
  typedef struct packed {
    logic [31:0] prdata;
    logic pslverr;
    logic done;
    logic [`PSIF_STOP_MSB:0] stop_reason;
    logic [`PSIF_BYTE_MSB:0] form;
    logic irq_enable;
    logic mask_done;
  } psif_regs_s;
  typedef struct packed {
    psif_prep_e state;
  } psif_prep_s;
endpackage

// ===== logic/psif_prep_seq.sv
// operand conversion sequencer run ahead of a modular multiplication
`timescale 1ns/1ns
`include "psif_params.svh"
module psif_prep_seq
  import psif_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic is_modmul,
  input wire psif_form_s form,
  input wire logic conv_ack,
  output psif_conv_s conv,
  output logic compute_go
);
  psif_prep_s st;
  psif_prep_s next_st;
  logic need;

  always_comb begin
    case (st.state)
      PSIF_CONV_J0: need = ~form.aff0;
      PSIF_CONV_M0: need = ~form.mon0;
      PSIF_CONV_J1: need = ~form.aff1;
      PSIF_CONV_M1: need = ~form.mon1;
      default: need = 1'b0;
    endcase
  end

  assign conv.req = need;
  assign conv.operand = (st.state == PSIF_CONV_J1) ||
                        (st.state == PSIF_CONV_M1);
  assign conv.to_mont = (st.state == PSIF_CONV_M0) ||
                        (st.state == PSIF_CONV_M1);
  assign compute_go = (st.state == PSIF_RUN);

  always_comb begin
    next_st = st;
    case (st.state)
      PSIF_IDLE: begin
        // RULE12 conversions before compute
        if (start && is_modmul) begin
          next_st.state = PSIF_CONV_J0;
        end else if (start) begin
          next_st.state = PSIF_RUN;
        end
      end
      // RULE13 montgomery step follows jacobian
      PSIF_CONV_J0: if (!need || conv_ack) next_st.state = PSIF_CONV_M0;
      PSIF_CONV_M0: if (!need || conv_ack) next_st.state = PSIF_CONV_J1;
      PSIF_CONV_J1: if (!need || conv_ack) next_st.state = PSIF_CONV_M1;
      PSIF_CONV_M1: if (!need || conv_ack) next_st.state = PSIF_RUN;
      PSIF_RUN: next_st.state = PSIF_IDLE;
      default: next_st.state = PSIF_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st.state <= PSIF_IDLE;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  first_jac_a: assert property ( // RULE12
    (st.state == PSIF_IDLE && start && is_modmul && !form.aff0)
      |=> conv.req && !conv.operand && !conv.to_mont && !compute_go)
    else $error("jacobian conversion of first operand not requested");
  first_mont_a: assert property ( // RULE13
    (st.state == PSIF_IDLE && start && is_modmul && form.aff0 &&
     !form.mon0) |=> ##1 conv.req && conv.to_mont && !conv.operand)
    else $error("montgomery conversion of first operand not requested");
endmodule

// ===== logic/psif_top.sv
// status, stop reason and operand input form registers on an apb slave
`timescale 1ns/1ns
`include "psif_params.svh"
// Operation
// RULE1: the done flag sets when an engine operation finishes.
// RULE2: software clears the done flag by writing one to it.
// RULE3: irq is high while done is set and interrupt enable is on; the code also requires the done mask bit to be one.
// RULE4: the same one-write also drops the pending interrupt.
// RULE5: a read-only four-bit stop reason reads zero after normal end.
// RULE6: a non-zero stop reason marks the result as invalid for software.
// RULE7: stop codes are 1 halt, 2 no inverse, 3 off curve, 4 bad microcode.
// RULE8: form bit 0 says the first operand is affine, else jacobian.
// RULE9: form bit 1 says the first operand is already montgomery.
// RULE10: form bit 2 says the second operand is affine, else jacobian.
// RULE11: form bit 3 says the second operand is already montgomery.
// RULE12: for modmul a jacobian conversion precedes compute when bit low.
// RULE13: for modmul a montgomery conversion precedes compute when bit low.
// RULE14: irq can only rise while interrupt enable bit 8 is one.
// RULE15: status updates the same whether interrupts are enabled or not.
// RULE16: writing zero or reserved bits leaves flag, code and irq alone.
module psif_top
  import psif_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PSIF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic op_start,
  input wire logic op_is_modmul,
  input wire logic op_end,
  input wire psif_fault_s fault,
  input wire logic conv_ack,
  output psif_form_s form,
  output psif_conv_s conv,
  output logic compute_go,
  output logic irq
);
  localparam logic [`PSIF_ADDR_W-1:0] a_ctrl =
    `PSIF_BYTE_ADDR(`PSIF_IDX_CTRL);
  localparam logic [`PSIF_ADDR_W-1:0] a_status =
    `PSIF_BYTE_ADDR(`PSIF_IDX_STATUS);
  localparam logic [`PSIF_ADDR_W-1:0] a_stat_rsv1 =
    `PSIF_BYTE_ADDR(`PSIF_IDX_STAT_RSV1);
  localparam logic [`PSIF_ADDR_W-1:0] a_stat_rsv3 =
    `PSIF_BYTE_ADDR(`PSIF_IDX_STAT_RSV3);
  localparam logic [`PSIF_ADDR_W-1:0] a_stop =
    `PSIF_BYTE_ADDR(`PSIF_IDX_STOP);
  localparam logic [`PSIF_ADDR_W-1:0] a_stop_rsv1 =
    `PSIF_BYTE_ADDR(`PSIF_IDX_STOP_RSV1);
  localparam logic [`PSIF_ADDR_W-1:0] a_stop_rsv2 =
    `PSIF_BYTE_ADDR(`PSIF_IDX_STOP_RSV2);
  localparam logic [`PSIF_ADDR_W-1:0] a_stop_rsv3 =
    `PSIF_BYTE_ADDR(`PSIF_IDX_STOP_RSV3);
  localparam logic [`PSIF_ADDR_W-1:0] a_mask =
    `PSIF_BYTE_ADDR(`PSIF_IDX_MASK);
  localparam logic [`PSIF_ADDR_W-1:0] a_form =
    `PSIF_BYTE_ADDR(`PSIF_IDX_FORM);

  psif_regs_s st;
  psif_regs_s next_st;
  logic setup;
  logic wr_access;
  logic hit;
  logic [31:0] rd_word;
  logic engine_end;
  logic [`PSIF_STOP_MSB:0] stop_code;
  logic clear_done;

  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign engine_end = op_end || (|fault);

  // RULE2 one-write clear of done
  // RULE16 zero bits never clear
  assign clear_done = wr_access && (paddr == a_status) &&
                      pstrb[`PSIF_LANE0] && pwdata[`PSIF_DONE_BIT];

  // RULE7 halt outranks every other stop cause
  always_comb begin
    stop_code = `PSIF_STOP_NORMAL;
    if (fault.bad_ucode) begin
      stop_code = `PSIF_STOP_BAD_UCODE;
    end
    if (fault.off_curve) begin
      stop_code = `PSIF_STOP_OFF_CURVE;
    end
    if (fault.no_inverse) begin
      stop_code = `PSIF_STOP_NO_INVERSE;
    end
    if (fault.halt) begin
      stop_code = `PSIF_STOP_HALT;
    end
  end

  // reserved words decode as hits and read zero
  always_comb begin
    rd_word = `PSIF_WORD_ZERO;
    hit = 1'b1;
    case (paddr)
      a_ctrl: rd_word[`PSIF_INTERRUPT_ENABLE_BIT_BIT] = st.irq_enable;
      a_status: rd_word[`PSIF_DONE_BIT] = st.done;
      a_stop: rd_word[`PSIF_STOP_MSB:0] = st.stop_reason;
      a_mask: rd_word[`PSIF_DONE_BIT] = st.mask_done;
      a_form: rd_word[`PSIF_BYTE_MSB:0] = st.form;
      a_stat_rsv1, a_stat_rsv3: rd_word = `PSIF_WORD_ZERO;
      a_stop_rsv1, a_stop_rsv2, a_stop_rsv3: rd_word = `PSIF_WORD_ZERO;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    // read data taken in setup so it leaves a flop with zero wait
    if (setup) begin
      next_st.prdata = pwrite ? `PSIF_WORD_ZERO : rd_word;
      next_st.pslverr = !hit;
    end
    // RULE1 set wins over a same-cycle clear
    // RULE15 flag path ignores interrupt enable
    next_st.done = engine_end || (st.done && !clear_done);
    // RULE5 loaded only at operation end, zero when normal
    if (engine_end) begin
      next_st.stop_reason = stop_code;
    end
    if (wr_access && paddr == a_form && pstrb[`PSIF_LANE0]) begin
      next_st.form = pwdata[`PSIF_BYTE_MSB:0];
    end
    if (wr_access && paddr == a_ctrl && pstrb[`PSIF_LANE1]) begin
      next_st.irq_enable = pwdata[`PSIF_INTERRUPT_ENABLE_BIT_BIT];
    end
    if (wr_access && paddr == a_mask && pstrb[`PSIF_LANE0]) begin
      next_st.mask_done = pwdata[`PSIF_DONE_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st.prdata <= `PSIF_WORD_ZERO;
      st.pslverr <= 1'b0;
      st.done <= `PSIF_FLAG_RESET;
      st.stop_reason <= `PSIF_STOP_NORMAL;
      st.form <= `PSIF_FORM_RESET;
      st.irq_enable <= `PSIF_FLAG_RESET;
      st.mask_done <= `PSIF_FLAG_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pslverr = st.pslverr;
  assign pready = 1'b1;

  // RULE8 RULE9 RULE10 RULE11 form bits straight from the register
  assign form = psif_form_s'(st.form[`PSIF_FORM_MSB:0]);

  // RULE3 RULE14 irq gated by enable and mask
  // RULE4 falls the cycle after the clearing write
  assign irq = st.done && st.irq_enable && st.mask_done;

  psif_prep_seq psif_prep_seq_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(op_start),
    .is_modmul(op_is_modmul),
    .form(form),
    .conv_ack(conv_ack),
    .conv(conv),
    .compute_go(compute_go)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence status_w1c_s;
    psel && penable && pwrite && paddr == a_status &&
    pstrb[`PSIF_LANE0] && pwdata[`PSIF_DONE_BIT];
  endsequence

  sequence status_w0_s;
    psel && penable && pwrite && paddr == a_status &&
    !(pstrb[`PSIF_LANE0] && pwdata[`PSIF_DONE_BIT]);
  endsequence

  sequence quiet_engine_s;
    !op_end && !(|fault);
  endsequence

  sequence enabled_event_s;
    engine_end && st.irq_enable && st.mask_done && !clear_done;
  endsequence

  done_set_a: assert property ( // RULE1
    op_end |=> st.done ##1 (st.done || $past(clear_done)))
    else $error("done flag did not set after operation end");

  done_clear_a: assert property ( // RULE2
    (status_w1c_s and quiet_engine_s) |=> !st.done)
    else $error("done flag survived a one-write");

  set_wins_a: assert property ( // RULE2
    (status_w1c_s and op_end) |=> st.done)
    else $error("operation end lost against clearing write");

  irq_raise_a: assert property ( // RULE3
    (enabled_event_s and !(psel && penable && pwrite))
      |=> irq ##1 (irq || !st.done || !st.irq_enable || !st.mask_done))
    else $error("irq not raised for enabled completion");

  irq_clear_a: assert property ( // RULE4
    (status_w1c_s and quiet_engine_s and irq) |=> !irq && !st.done)
    else $error("irq still high after one-write");

  stop_normal_a: assert property ( // RULE5
    (op_end && !(|fault)) |=> st.stop_reason == `PSIF_STOP_NORMAL)
    else $error("stop reason not zero after normal end");

  stop_hold_a: assert property ( // RULE5
    quiet_engine_s |=> $stable(st.stop_reason))
    else $error("stop reason changed without an operation end");

  stop_read_a: assert property ( // RULE6
    (psel && !penable && !pwrite && paddr == a_stop)
      |=> prdata[`PSIF_STOP_MSB:0] == $past(st.stop_reason) &&
          !pslverr)
    else $error("stop reason read back wrong");

  halt_code_a: assert property ( // RULE7
    fault.halt |=> st.stop_reason == `PSIF_STOP_HALT && st.done)
    else $error("halt not logged as code one");

  inverse_code_a: assert property ( // RULE7
    (fault.no_inverse && !fault.halt)
      |=> st.stop_reason == `PSIF_STOP_NO_INVERSE)
    else $error("missing inverse not logged as code two");

  curve_code_a: assert property ( // RULE7
    (fault.off_curve && !fault.halt && !fault.no_inverse)
      |=> st.stop_reason == `PSIF_STOP_OFF_CURVE)
    else $error("off curve point not logged as code three");

  ucode_code_a: assert property ( // RULE7
    (fault == psif_fault_s'(4'b0001))
      |=> st.stop_reason == `PSIF_STOP_BAD_UCODE)
    else $error("bad microcode not logged as code four");

  form_write_a: assert property ( // RULE8
    (psel && penable && pwrite && paddr == a_form && pstrb[`PSIF_LANE0])
      |=> form == psif_form_s'($past(pwdata[`PSIF_FORM_MSB:0])))
    else $error("form outputs do not follow the written byte");

  form_first_a: assert property ( // RULE9
    (psel && penable && pwrite && paddr == a_form && pstrb[`PSIF_LANE0])
      |=> form.mon0 == $past(pwdata[1]) && form.aff0 == $past(pwdata[0]))
    else $error("first operand form bits misplaced");

  form_second_a: assert property ( // RULE10
    (psel && penable && pwrite && paddr == a_form && pstrb[`PSIF_LANE0])
      |=> form.aff1 == $past(pwdata[2]) && form.mon1 == $past(pwdata[3]))
    else $error("second operand form bits misplaced");

  form_keep_a: assert property ( // RULE11
    !(psel && penable && pwrite && paddr == a_form) |=> $stable(form))
    else $error("form changed without a form write");

  irq_gate_a: assert property ( // RULE14
    !st.irq_enable |-> !irq)
    else $error("irq high while interrupt enable is off");

  status_indep_a: assert property ( // RULE15
    (op_end && !st.irq_enable) |=> st.done && !irq)
    else $error("done flag depends on interrupt enable");

  zero_write_a: assert property ( // RULE16
    (status_w0_s and quiet_engine_s)
      |=> $stable(st.done) && $stable(st.stop_reason) && $stable(irq))
    else $error("zero write disturbed status");

  stop_write_a: assert property ( // RULE16
    (psel && penable && pwrite && paddr == a_stop and quiet_engine_s)
      |=> $stable(st.stop_reason) && $stable(st.done))
    else $error("write to stop reason had an effect");

  status_read_a: assert property ( // RULE1
    (setup && !pwrite && paddr == a_status)
      |=> prdata == {31'h0000_0000, $past(st.done)} && !pslverr)
    else $error("status read back wrong");

  done_sticky_a: assert property ( // RULE1
    (st.done && !clear_done) |=> st.done)
    else $error("done flag dropped without a clearing write");

  done_idle_a: assert property ( // RULE1
    (!st.done && !engine_end) |=> !st.done)
    else $error("done flag set without an operation end");

  stop_upper_a: assert property ( // RULE5
    (setup && !pwrite && paddr == a_stop)
      |=> prdata[31:`PSIF_STOP_MSB+1] == 28'h000_0000)
    else $error("stop reason upper bits not zero");

  fault_code_a: assert property ( // RULE6
    (|fault) |=> st.stop_reason != `PSIF_STOP_NORMAL && st.done)
    else $error("failed operation logged as normal end");

  irq_source_a: assert property ( // RULE3
    irq |-> st.done && st.mask_done)
    else $error("irq high without a pending unmasked flag");

  irq_en_write_a: assert property ( // RULE14
    (wr_access && paddr == a_ctrl && pstrb[`PSIF_LANE1])
      |=> st.irq_enable == $past(pwdata[`PSIF_INTERRUPT_ENABLE_BIT_BIT]))
    else $error("interrupt enable did not take the written bit");

  ctrl_read_a: assert property ( // RULE14
    (setup && !pwrite && paddr == a_ctrl)
      |=> prdata[`PSIF_INTERRUPT_ENABLE_BIT_BIT] == $past(st.irq_enable) && !pslverr)
    else $error("interrupt enable read back wrong");

  form_read_a: assert property ( // RULE8
    (setup && !pwrite && paddr == a_form)
      |=> prdata[`PSIF_BYTE_MSB:0] == $past(st.form) && !pslverr)
    else $error("form register read back wrong");

  rsv_write_a: assert property ( // RULE16
    ((wr_access && (paddr == a_stat_rsv1 || paddr == a_stat_rsv3))
      and quiet_engine_s) |=> $stable(st.done) && $stable(irq))
    else $error("write to a reserved word had an effect");

  mask_write_a: assert property ( // RULE3
    (wr_access && paddr == a_mask && pstrb[`PSIF_LANE0])
      |=> st.mask_done == $past(pwdata[`PSIF_DONE_BIT]))
    else $error("mask bit did not take the written value");

  irq_off_a: assert property ( // RULE14
    (wr_access && paddr == a_ctrl && pstrb[`PSIF_LANE1] &&
     !pwdata[`PSIF_INTERRUPT_ENABLE_BIT_BIT]) |=> !irq)
    else $error("irq stayed high after interrupt enable cleared");
endmodule

// ===== verification/psif_top_test.sv
// self-checking bench for the status, stop reason and input form block
`timescale 1ns/1ns
`include "psif_params.svh"
module psif_top_test
  import psif_pkg::*;
;
  localparam logic [17:0] a_ctrl = `PSIF_BYTE_ADDR(`PSIF_IDX_CTRL);
  localparam logic [17:0] a_stat = `PSIF_BYTE_ADDR(`PSIF_IDX_STATUS);
  localparam logic [17:0] a_rsv = `PSIF_BYTE_ADDR(`PSIF_IDX_STAT_RSV1);
  localparam logic [17:0] a_stop = `PSIF_BYTE_ADDR(`PSIF_IDX_STOP);
  localparam logic [17:0] a_mask = `PSIF_BYTE_ADDR(`PSIF_IDX_MASK);
  localparam logic [17:0] a_form = `PSIF_BYTE_ADDR(`PSIF_IDX_FORM);
  localparam logic [17:0] a_none = 18'h0_0100;
  logic ref_clk;
  logic reset;
  logic psel;
  logic penable;
  logic pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic op_start;
  logic op_is_modmul;
  logic op_end;
  psif_fault_s fault;
  logic conv_ack;
  psif_form_s form;
  psif_conv_s conv;
  logic compute_go;
  logic irq;
  int error_cnt;
  int tests_run;
  int cyc;
  logic [3:0] strb_sel;

  psif_top psif_top_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .op_start(op_start),
    .op_is_modmul(op_is_modmul),
    .op_end(op_end),
    .fault(fault),
    .conv_ack(conv_ack),
    .form(form),
    .conv(conv),
    .compute_go(compute_go),
    .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // hang guard, the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [17:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb_sel;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // the write lands at this edge, so let it settle before callers look
    #1;
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask

  // one-cycle engine event, outputs looked at once the edge has landed
  task automatic ev(input logic e, input psif_fault_s f);
    @(posedge ref_clk);
    op_end <= e;
    fault <= f;
    @(posedge ref_clk);
    op_end <= 1'b0;
    fault <= 4'h0;
    #1;
  endtask

  task automatic test_reset();
    chk({31'h0, irq}, 32'h0000_0000);
    chk({28'h0, form}, 32'h0000_000a);
    chk({31'h0, pready}, 32'h0000_0001);
    rd_chk(a_stat, 32'h0000_0000, 1'b0);
    rd_chk(a_stop, 32'h0000_0000, 1'b0);
    rd_chk(a_form, 32'h0000_002a, 1'b0);
    rd_chk(a_ctrl, 32'h0000_0000, 1'b0);
    rd_chk(a_mask, 32'h0000_0000, 1'b0);
    rd_chk(a_rsv, 32'h0000_0000, 1'b0);
    rd_chk(a_none, 32'h0000_0000, 1'b1);
    $display("test reset finished");
  endtask

  task automatic test_done_irq();
    wr(a_ctrl, 32'h0000_0100);
    wr(a_mask, 32'h0000_0001);
    ev(1'b1, 4'h0);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(a_stat, 32'h0000_0001, 1'b0);
    rd_chk(a_stop, 32'h0000_0000, 1'b0);
    // a one with lane 0 strobed off must not clear
    strb_sel = 4'he;
    wr(a_stat, 32'h0000_0001);
    strb_sel = 4'hf;
    wr(a_stat, 32'h0000_0000);
    wr(a_stop, 32'h0000_000f);
    wr(a_rsv, 32'hffff_ffff);
    wr(a_none, 32'hffff_ffff);
    chk({31'h0, irq}, 32'h0000_0001);
    rd_chk(a_stat, 32'h0000_0001, 1'b0);
    rd_chk(a_stop, 32'h0000_0000, 1'b0);
    // masking hides the pending flag, unmasking shows it again
    wr(a_mask, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(a_mask, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(a_stat, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(a_stat, 32'h0000_0000, 1'b0);
    $display("test done_irq finished");
  endtask

  task automatic test_codes();
    for (int i = 0; i < 4; i++) begin
      ev(1'b0, 4'b1000 >> i);
      rd_chk(a_stop, i + 1, 1'b0);
      rd_chk(a_stat, 32'h0000_0001, 1'b0);
      wr(a_stat, 32'h0000_0001);
    end
    ev(1'b0, 4'hf);
    rd_chk(a_stop, 32'h0000_0001, 1'b0);
    ev(1'b1, 4'h0);
    rd_chk(a_stop, 32'h0000_0000, 1'b0);
    wr(a_stat, 32'h0000_0001);
    $display("test codes finished");
  endtask

  task automatic test_no_irq();
    wr(a_ctrl, 32'h0000_0000);
    ev(1'b1, 4'h0);
    chk({31'h0, irq}, 32'h0000_0000);
    rd_chk(a_stat, 32'h0000_0001, 1'b0);
    wr(a_ctrl, 32'h0000_0100);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(a_stat, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test no_irq finished");
  endtask

  task automatic test_form();
    logic [7:0] v;
    for (int i = 0; i < 2; i++) begin
      v = (i == 0) ? 8'h05 : 8'h0a;
      wr(a_form, {24'h0, v});
      rd_chk(a_form, {24'h0, v}, 1'b0);
      chk({31'h0, form.aff0}, {31'h0, v[0]});
      chk({31'h0, form.mon0}, {31'h0, v[1]});
      chk({31'h0, form.aff1}, {31'h0, v[2]});
      chk({31'h0, form.mon1}, {31'h0, v[3]});
    end
    $display("test form finished");
  endtask

  // step k of the walk: operand k/2, montgomery when k is odd, form bit k
  task automatic test_conv(input logic [3:0] fv, input logic mm);
    int k;
    int nconv;
    int nexp;
    logic go;
    k = 0;
    nconv = 0;
    go = 1'b0;
    nexp = 0;
    for (int i = 0; i < 4; i++) begin
      if (mm && !fv[i]) begin
        nexp++;
      end
    end
    wr(a_form, {28'h0, fv});
    @(posedge ref_clk);
    op_start <= 1'b1;
    op_is_modmul <= mm;
    @(posedge ref_clk);
    op_start <= 1'b0;
    for (int n = 0; n < 40 && !go; n++) begin
      @(posedge ref_clk);
      if (compute_go === 1'b1) begin
        go = 1'b1;
      end else if (conv.req === 1'b1) begin
        while (k < 4 && fv[k]) begin
          k++;
        end
        chk({30'h0, conv.operand, conv.to_mont}, k % 4);
        k++;
        nconv++;
        conv_ack <= 1'b1;
        @(posedge ref_clk);
        conv_ack <= 1'b0;
      end
    end
    chk(nconv, nexp);
    chk({31'h0, go}, 32'h0000_0001);
    $display("test conv form %h modmul %b finished", fv, mm);
  endtask

  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h0_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    strb_sel = 4'hf;
    op_start = 1'b0;
    op_is_modmul = 1'b0;
    op_end = 1'b0;
    fault = 4'h0;
    conv_ack = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    cyc = 0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    test_reset();
    test_done_irq();
    test_codes();
    test_no_irq();
    test_form();
    test_conv(4'h0, 1'b1);
    test_conv(4'h5, 1'b1);
    test_conv(4'ha, 1'b1);
    test_conv(4'hf, 1'b1);
    test_conv(4'h0, 1'b0);
    report_and_stop();
  end
endmodule
